// ==== hdl/rtcac_match.sv ====
// rtcac_match: compares calendar and alarm digits for the fields the interval leaves unmasked
// assumes second_edge marks the tick that starts a new whole second
`timescale 1ns/10ps
`default_nettype none
module rtcac_match
	import rtcac_pkg::*;
(
	input  wire logic       second_edge,
	input  wire rtcac_cal_t cur_time,
	input  wire rtcac_cal_t alarm_time,
	input  wire logic [3:0] interval,
	output logic            match
);
	wire m_s01 = cur_time.sec01 == alarm_time.sec01;
	wire m_s10 = cur_time.sec10 == alarm_time.sec10;
	wire m_m01 = cur_time.min01 == alarm_time.min01;
	wire m_m10 = cur_time.min10 == alarm_time.min10;
	wire m_hr  = {cur_time.hr10, cur_time.hr01} == {alarm_time.hr10, alarm_time.hr01};
	wire m_wd  = cur_time.wday == alarm_time.wday;
	wire m_day = {cur_time.day10, cur_time.day01} == {alarm_time.day10, alarm_time.day01};
	wire m_mon = {cur_time.mon10, cur_time.mon01} == {alarm_time.mon10, alarm_time.mon01};

	// each coarser interval adds one more field to a finer one; week and month both extend day
	wire t_10s = second_edge & m_s01;
	wire t_min = t_10s & m_s10;
	wire t_10m = t_min & m_m01;
	wire t_hr  = t_10m & m_m10;
	wire t_day = t_hr & m_hr;
	wire t_wk  = t_day & m_wd;
	wire t_mo  = t_day & m_day;
	// feb 29 only exists in leap years, so a yearly match there fires every four years
	wire t_yr  = t_mo & m_mon;

	always_comb begin
		case (interval)
			RTCAC_IV_HALFSEC: match = 1'b1;
			RTCAC_IV_SECOND:  match = second_edge;
			RTCAC_IV_10SEC:   match = t_10s;
			RTCAC_IV_MINUTE:  match = t_min;
			RTCAC_IV_10MIN:   match = t_10m;
			RTCAC_IV_HOUR:    match = t_hr;
			RTCAC_IV_DAY:     match = t_day;
			RTCAC_IV_WEEK:    match = t_wk;
			RTCAC_IV_MONTH:   match = t_mo;
			RTCAC_IV_YEAR:    match = t_yr;
			default:          match = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ==== hdl/rtcac_pkg.sv ====
// rtcac_pkg: offsets, control layout, calendar carrier and interval codes for the alarm control
// assumes a 32-bit apb slave with byte addresses; the calendar digits arrive as packed bcd nibbles
`default_nettype none
package rtcac_pkg;
	// apb byte offsets
	localparam logic [7:0] RTCAC_OFF_CTRL     = 8'h00;
	localparam logic [7:0] RTCAC_OFF_CLR      = 8'h04;
	localparam logic [7:0] RTCAC_OFF_SET      = 8'h08;
	localparam logic [7:0] RTCAC_OFF_INV      = 8'h0C;
	localparam logic [7:0] RTCAC_OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] RTCAC_OFF_IRQ_CLR  = 8'h14;
	localparam logic [7:0] RTCAC_OFF_IRQ_EN   = 8'h18;

	// control reset value, power-on only
	localparam logic [15:0] RTCAC_CTRL_RESET = 16'h0000;
	// repeat count reload on rollover
	localparam logic [7:0]  RTCAC_RPT_WRAP   = 8'hFF;
	// read-unsafe guard, in clock-unit clocks
	localparam int unsigned RTCAC_GUARD_CLKS = 32;

	// interrupt layout
	localparam int unsigned RTCAC_IRQ_W       = 2;
	localparam int unsigned RTCAC_IRQ_ALARM   = 0;
	localparam int unsigned RTCAC_IRQ_AUTOOFF = 1;

	// control word, msb first, bit 15 down to bit 0
	typedef struct packed {
		logic       alarm_enable;
		logic       repeat_rollover;
		logic       pulse_start_level;
		logic       alarm_read_unsafe;
		logic [3:0] alarm_interval_select;
		logic [7:0] alarm_repeat_count;
	} rtcac_ctrl_t;

	typedef enum logic [3:0] {
		RTCAC_IV_HALFSEC = 4'h0,
		RTCAC_IV_SECOND  = 4'h1,
		RTCAC_IV_10SEC   = 4'h2,
		RTCAC_IV_MINUTE  = 4'h3,
		RTCAC_IV_10MIN   = 4'h4,
		RTCAC_IV_HOUR    = 4'h5,
		RTCAC_IV_DAY     = 4'h6,
		RTCAC_IV_WEEK    = 4'h7,
		RTCAC_IV_MONTH   = 4'h8,
		RTCAC_IV_YEAR    = 4'h9
	} rtcac_intv_t;

	typedef struct packed {
		logic [3:0] mon10;
		logic [3:0] mon01;
		logic [3:0] day10;
		logic [3:0] day01;
		logic [3:0] wday;
		logic [3:0] hr10;
		logic [3:0] hr01;
		logic [3:0] min10;
		logic [3:0] min01;
		logic [3:0] sec10;
		logic [3:0] sec01;
	} rtcac_cal_t;
endpackage
`default_nettype wire

// ==== hdl/rtcac_sticky.sv ====
// rtcac_sticky: sticky event bits, write-one-to-clear, enable mask, one level interrupt
// assumes set pulses and clear strobes are synchronous to clock
`timescale 1ns/10ps
`default_nettype none
module rtcac_sticky #(
	parameter int unsigned W = 2
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	input  wire logic         en_wr,
	input  wire logic [W-1:0] en_wdata,
	output logic [W-1:0]      status_q,
	output logic [W-1:0]      enable_q,
	output logic              irq
);
	if (W < 1) begin : g_chk
		$error("rtcac_sticky needs at least one bit");
	end

	// a set in the clearing cycle survives
	wire [W-1:0] status_d = (status_q & ~clr) | set;
	wire [W-1:0] enable_d = en_wr ? en_wdata : enable_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status_q <= '0;
			enable_q <= '0;
		end else begin
			status_q <= status_d;
			enable_q <= enable_d;
		end
	end

	assign irq = |(status_q & enable_q);
endmodule
`default_nettype wire

// ==== hdl/rtcac_top.sv ====
// rtcac_top: alarm control register, repeat counter, alarm pulse and read-unsafe flag on apb
// assumes resetn is the power-on reset and the calendar inputs change only on halfsec_tick
//
// Behaviour
// - bit 15 enables alarm generation; zero turns it off.
// - with rollover set the repeat count wraps from 0x00 to 0xFF.
// - with rollover clear the repeat count stops at 0x00.
// - while disabled, the pulse start bit is writable and sets the pulse level.
// - while enabled, the pulse bit ignores writes and reads the live pulse.
// - read-unsafe flag clears only when prescaler is more than 32 clocks from rollover.
// - repeat count and enable reach the bus through a sampling stage.
// - the 4-bit interval field picks the alarm period; codes 1010-1111 never fire.
// - code 1001 fires yearly; a february 29 alarm fires every four years.
// - an alarm at count zero without rollover clears the enable bit.
// - the control register resets only on power-on reset.
// - bits 31 to 16 of the control register read as zero.
// - clear, set and invert aliases at offsets 0x4, 0x8, 0xC.
`timescale 1ns/10ps
`default_nettype none
module rtcac_top
	import rtcac_pkg::*;
#(
	parameter int unsigned PRE_W = 16
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic [7:0]       paddr,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             halfsec_tick,
	input  wire logic             second_edge,
	input  wire logic [PRE_W-1:0] prescaler_remaining,
	input  wire rtcac_cal_t       cur_time,
	input  wire rtcac_cal_t       alarm_time,
	output logic                  alarm_pulse,
	output logic                  alarm_event,
	output logic                  irq
);
	if (PRE_W < 6) begin : g_chk
		$error("prescaler distance must be wide enough to hold the guard count");
	end

	localparam logic [PRE_W-1:0] GUARD = PRE_W'(RTCAC_GUARD_CLKS);

	rtcac_ctrl_t       ctrl_q;
	rtcac_ctrl_t       ctrl_d;
	logic [31:0]       prdata_q;
	logic              alarm_event_q;
	logic              match;
	logic [RTCAC_IRQ_W-1:0] irq_status;
	logic [RTCAC_IRQ_W-1:0] irq_enable;

	// bus phases; the slave never stalls
	wire setup  = psel & ~penable;
	wire access = psel & penable;
	wire wr     = access & pwrite;

	wire hit_ctrl = paddr == RTCAC_OFF_CTRL;
	wire hit_clr  = paddr == RTCAC_OFF_CLR;
	wire hit_set  = paddr == RTCAC_OFF_SET;
	wire hit_inv  = paddr == RTCAC_OFF_INV;
	wire hit_ist  = paddr == RTCAC_OFF_IRQ_STAT;
	wire hit_icl  = paddr == RTCAC_OFF_IRQ_CLR;
	wire hit_ien  = paddr == RTCAC_OFF_IRQ_EN;
	wire hit_any_ctrl = hit_ctrl | hit_clr | hit_set | hit_inv;
	wire hit_any  = hit_any_ctrl | hit_ist | hit_icl | hit_ien;
	wire wr_ctrl  = wr & hit_any_ctrl;

	// software view of the new control word, alias operations applied
	wire [15:0] cur_w = ctrl_q;
	wire [15:0] wd    = pwdata[15:0];
	wire [15:0] op_w  = hit_ctrl ? wd :
	                    hit_clr  ? (cur_w & ~wd) :
	                    hit_set  ? (cur_w | wd) :
	                    (cur_w ^ wd);
	rtcac_ctrl_t op_c;
	assign op_c = op_w;

	rtcac_ctrl_t sw_c;
	always_comb begin
		sw_c = ctrl_q;
		if (wr_ctrl) begin
			sw_c = op_c;
			sw_c.alarm_read_unsafe = ctrl_q.alarm_read_unsafe;
			// pulse level is locked once the alarm runs
			if (ctrl_q.alarm_enable) begin
				sw_c.pulse_start_level = ctrl_q.pulse_start_level;
			end
		end
	end

	rtcac_match u_match (
		.second_edge (second_edge),
		.cur_time    (cur_time),
		.alarm_time  (alarm_time),
		.interval    (ctrl_q.alarm_interval_select),
		.match       (match)
	);

	// an alarm only exists while enabled
	wire ev       = halfsec_tick & ctrl_q.alarm_enable & match;
	wire rpt_zero = sw_c.alarm_repeat_count == 8'h00;
	wire auto_off = ev & rpt_zero & ~sw_c.repeat_rollover;

	// hardware effects land after the software write in the same cycle
	always_comb begin
		ctrl_d = sw_c;
		if (ev) begin
			ctrl_d.pulse_start_level = ~sw_c.pulse_start_level;
			if (!rpt_zero) begin
				ctrl_d.alarm_repeat_count = sw_c.alarm_repeat_count - 8'h01;
			end else if (sw_c.repeat_rollover) begin
				ctrl_d.alarm_repeat_count = RTCAC_RPT_WRAP;
			end
			if (auto_off) begin
				ctrl_d.alarm_enable = 1'b0;
			end
		end
		// the guard assumes the bus read finishes well inside it
		ctrl_d.alarm_read_unsafe = prescaler_remaining <= GUARD;
	end

	// resetn is the power-on reset; no other reset reaches this register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_q        <= RTCAC_CTRL_RESET;
			alarm_event_q <= 1'b0;
		end else begin
			ctrl_q        <= ctrl_d;
			alarm_event_q <= ev;
		end
	end

	rtcac_sticky #(
		.W (RTCAC_IRQ_W)
	) u_sticky (
		.clock    (clock),
		.resetn   (resetn),
		.set      ({auto_off, ev}),
		.clr      (wr & hit_icl ? pwdata[RTCAC_IRQ_W-1:0] : '0),
		.en_wr    (wr & hit_ien),
		.en_wdata (pwdata[RTCAC_IRQ_W-1:0]),
		.status_q (irq_status),
		.enable_q (irq_enable),
		.irq      (irq)
	);

	// read data is sampled in the setup cycle: count and enable may move after it,
	// which is why software rereads when the unsafe flag is up
	wire [31:0] rd_mux = hit_any_ctrl ? {16'h0000, cur_w} :
	                     hit_ist      ? {30'h0000_0000, irq_status} :
	                     hit_ien      ? {30'h0000_0000, irq_enable} :
	                     32'h0000_0000;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata      = prdata_q;
	assign pready      = 1'b1;
	assign pslverr     = access & ~hit_any;
	assign alarm_pulse = ctrl_q.pulse_start_level;
	assign alarm_event = alarm_event_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_alarm_q;
		ev && !wr_ctrl;
	endsequence

	sequence s_apb_read;
		setup && !pwrite && hit_any_ctrl ##1 access && !pwrite;
	endsequence

	a_rollover_wrap: assert property (
		s_alarm_q and (ctrl_q.repeat_rollover && ctrl_q.alarm_repeat_count == 8'h00)
		|=> ctrl_q.alarm_repeat_count == 8'hFF
	) else $error("repeat count did not wrap to 0xFF");

	a_stop_zero: assert property (
		s_alarm_q and (!ctrl_q.repeat_rollover && ctrl_q.alarm_repeat_count == 8'h00)
		|=> ctrl_q.alarm_repeat_count == 8'h00 && !ctrl_q.alarm_enable
	) else $error("repeat count left zero without rollover");

	a_auto_disable: assert property (
		s_alarm_q and (!ctrl_q.repeat_rollover && ctrl_q.alarm_repeat_count == 8'h00)
		|=> !ctrl_q.alarm_enable ##1 !alarm_event
	) else $error("enable not cleared after final alarm");

	a_pulse_toggle: assert property (
		s_alarm_q |=> alarm_pulse != $past(alarm_pulse) && alarm_event
	) else $error("alarm did not toggle the pulse");

	a_count_step: assert property (
		s_alarm_q and (ctrl_q.alarm_repeat_count != 8'h00)
		|=> ctrl_q.alarm_repeat_count == $past(ctrl_q.alarm_repeat_count) - 8'h01
	) else $error("repeat count did not step down by one");

	a_piv_locked: assert property (
		wr_ctrl && ctrl_q.alarm_enable && !ev |=> alarm_pulse == $past(alarm_pulse)
	) else $error("pulse level changed by a write while enabled");

	a_piv_write: assert property (
		wr && hit_ctrl && !ctrl_q.alarm_enable |=> alarm_pulse == $past(pwdata[13])
	) else $error("pulse start level not taken while disabled");

	a_unsafe_flag: assert property (
		##1 ctrl_q.alarm_read_unsafe == ($past(prescaler_remaining) <= GUARD)
	) else $error("read-unsafe flag disagrees with prescaler distance");

	a_event_enabled: assert property (
		alarm_event |-> $past(ctrl_q.alarm_enable)
	) else $error("alarm raised while disabled");

	a_half_every: assert property (
		halfsec_tick && ctrl_q.alarm_enable
		&& ctrl_q.alarm_interval_select == 4'h0 |=> alarm_event
	) else $error("half-second interval missed an alarm");

	a_reserved_quiet: assert property (
		ctrl_q.alarm_interval_select >= 4'hA |-> !ev
	) else $error("reserved interval raised an alarm");

	a_upper_zero: assert property (
		s_apb_read |-> prdata[31:16] == 16'h0000
	) else $error("upper control bits not zero on read");

	a_set_alias: assert property (
		wr && hit_set && !ev |=> (ctrl_q.alarm_interval_select & $past(pwdata[11:8]))
		== $past(pwdata[11:8])
	) else $error("set alias did not set interval bits");

	// a last alarm: count at zero, no rollover, no software write in the same cycle
	sequence s_last_alarm;
		ev && !wr_ctrl && !ctrl_q.repeat_rollover && ctrl_q.alarm_repeat_count == 8'h00;
	endsequence

	// without an alarm or a write, the control fields other than the read-unsafe flag keep their value
	a_enable_hold: assert property (
		!ev && !wr_ctrl |=> ctrl_q.alarm_enable == $past(ctrl_q.alarm_enable)
	) else $error("enable changed without alarm or write");

	a_count_hold: assert property (
		!ev && !wr_ctrl
		|=> ctrl_q.alarm_repeat_count == $past(ctrl_q.alarm_repeat_count)
	) else $error("repeat count changed without alarm or write");

	a_pulse_hold: assert property (
		!ev && !wr_ctrl |=> alarm_pulse == $past(alarm_pulse)
	) else $error("pulse changed without alarm or write");

	a_interval_hold: assert property (
		!wr_ctrl
		|=> ctrl_q.alarm_interval_select == $past(ctrl_q.alarm_interval_select)
	) else $error("interval changed without a write");

	a_event_off: assert property (
		!ctrl_q.alarm_enable |=> !alarm_event
	) else $error("alarm event while disabled");

	a_full_write: assert property (
		wr && hit_ctrl && !ev |=> ctrl_q.alarm_enable == $past(pwdata[15])
	) else $error("enable bit not taken from a control write");

	a_wrap_keep: assert property (
		s_alarm_q and (ctrl_q.repeat_rollover && ctrl_q.alarm_repeat_count == 8'h00)
		|=> ctrl_q.alarm_enable
	) else $error("rollover alarm switched the alarm off");

	a_mid_count: assert property (
		s_alarm_q and (ctrl_q.alarm_repeat_count != 8'h00) |=> ctrl_q.alarm_enable
	) else $error("alarm switched off with repeats left");

	a_auto_flag: assert property (
		s_last_alarm |=> irq_status[RTCAC_IRQ_AUTOOFF]
	) else $error("auto-disable status not set");

	a_stat_alarm: assert property (
		s_alarm_q |=> irq_status[RTCAC_IRQ_ALARM]
	) else $error("alarm status not set");

	a_unsafe_set: assert property (
		prescaler_remaining <= GUARD |=> ctrl_q.alarm_read_unsafe
	) else $error("read-unsafe flag low inside the guard window");

	a_unsafe_clear: assert property (
		prescaler_remaining > GUARD |=> !ctrl_q.alarm_read_unsafe
	) else $error("read-unsafe flag high outside the guard window");

	// read data is the control word of the setup cycle and stands until the next setup
	a_read_capture: assert property (
		s_apb_read |-> prdata[15:0] == $past(cur_w)
	) else $error("read data is not the control word of the setup cycle");

	a_read_stands: assert property (
		!setup |=> $stable(prdata)
	) else $error("read data moved outside a setup cycle");

	a_clear_alias: assert property (
		wr && hit_clr && !ev
		|=> (ctrl_q.alarm_interval_select & $past(pwdata[11:8])) == 4'h0
	) else $error("clear alias did not clear interval bits");

	a_inv_alias: assert property (
		wr && hit_inv |=> ctrl_q.alarm_interval_select
		== ($past(ctrl_q.alarm_interval_select) ^ $past(pwdata[11:8]))
	) else $error("invert alias did not toggle interval bits");

	a_set_count: assert property (
		wr && hit_set && !ev
		|=> (ctrl_q.alarm_repeat_count & $past(pwdata[7:0])) == $past(pwdata[7:0])
	) else $error("set alias did not set count bits");

	// an accepted alarm implies the fields its interval compares were equal
	a_event_match: assert property (
		alarm_event |-> $past(match)
	) else $error("alarm raised without a match");

	a_second_gate: assert property (
		halfsec_tick && !second_edge && ctrl_q.alarm_interval_select == RTCAC_IV_SECOND
		|=> !alarm_event
	) else $error("second interval fired off a whole second");

	a_tenth_match: assert property (
		ev && ctrl_q.alarm_interval_select == RTCAC_IV_10SEC
		|-> second_edge && cur_time.sec01 == alarm_time.sec01
	) else $error("ten-second alarm without a seconds match");

	a_week_match: assert property (
		ev && ctrl_q.alarm_interval_select == RTCAC_IV_WEEK
		|-> cur_time.wday == alarm_time.wday
	) else $error("weekly alarm without a weekday match");

	a_year_match: assert property (
		ev && ctrl_q.alarm_interval_select == RTCAC_IV_YEAR
		|-> {cur_time.mon10, cur_time.mon01, cur_time.day10, cur_time.day01}
		== {alarm_time.mon10, alarm_time.mon01, alarm_time.day10, alarm_time.day01}
	) else $error("yearly alarm without a date match");
endmodule
`default_nettype wire

// ==== sim/test_rtc_alarm_control.sv ====
// test_rtc_alarm_control: apb sequences against the alarm control block
// assumes rtcac_top with pready tied high and the default prescaler width
`timescale 1ns/10ps
`default_nettype none
module test_rtc_alarm_control;
	import rtcac_pkg::*;
	logic        clock;
	logic        resetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        halfsec_tick;
	logic        second_edge;
	logic [15:0] prescaler_remaining;
	rtcac_cal_t  cur_time;
	rtcac_cal_t  alarm_time;
	logic        alarm_pulse;
	logic        alarm_event;
	logic        irq;
	int          error_cnt;
	int          checked;
	logic [31:0] rd_q;
	logic        err;

	rtcac_top DUT (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .halfsec_tick(halfsec_tick),
		.second_edge(second_edge), .prescaler_remaining(prescaler_remaining),
		.cur_time(cur_time), .alarm_time(alarm_time), .alarm_pulse(alarm_pulse),
		.alarm_event(alarm_event), .irq(irq));

	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	task automatic complete_run;
		$display("errors %0d compares %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	// master holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 32);
		if (n >= 32) begin
			error_cnt++;
			$display("mismatch at %0t: no pready within the read limit", $time);
		end
		rd_q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		cmp32(rd_q, exp);
	endtask

	// one tick; the event shows one cycle after the tick is taken
	task automatic tick(input logic exp);
		@(posedge clock);
		halfsec_tick <= 1'b1;
		@(posedge clock);
		halfsec_tick <= 1'b0;
		#1;
		cmp1(alarm_event, exp);
	endtask

	task automatic do_reset;
		resetn <= 1'b0;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		resetn = 1'b0;
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		halfsec_tick = 1'b0;
		second_edge = 1'b1;
		prescaler_remaining = 16'h0400;
		cur_time = '0;
		alarm_time = '0;
		error_cnt = 0;
		checked = 0;
		do_reset();
		rdc(RTCAC_OFF_CTRL, 32'h0000_0000);
		// upper half and the read-unsafe bit never take a write
		apb(1'b1, RTCAC_OFF_CTRL, 32'hFFFF_1055);
		rdc(RTCAC_OFF_CTRL, 32'h0000_0055);
		apb(1'b1, RTCAC_OFF_SET, 32'h0000_0F00);
		rdc(RTCAC_OFF_CTRL, 32'h0000_0F55);
		apb(1'b1, RTCAC_OFF_CLR, 32'h0000_0005);
		rdc(RTCAC_OFF_INV, 32'h0000_0F50);
		apb(1'b1, RTCAC_OFF_INV, 32'h0000_00FF);
		rdc(RTCAC_OFF_CTRL, 32'h0000_0FAF);
		tick(1'b0);
		apb(1'b0, 8'h20, 32'h0000_0000);
		cmp32(rd_q, 32'h0000_0000);
		cmp1(err, 1'b1);
		// boundary of the read-unsafe window
		prescaler_remaining <= 16'd33;
		repeat (3) @(posedge clock);
		rdc(RTCAC_OFF_CTRL, 32'h0000_0FAF);
		prescaler_remaining <= 16'd32;
		repeat (3) @(posedge clock);
		rdc(RTCAC_OFF_CTRL, 32'h0000_1FAF);
		// flag up: a second read must agree before the count is trusted
		rdc(RTCAC_OFF_CTRL, 32'h0000_1FAF);
		// leave the guard window before any control write
		prescaler_remaining <= 16'h0400;
		apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_2000);
		@(posedge clock);
		#1;
		cmp1(alarm_pulse, 1'b1);
		// still disabled here, so the pulse level is written along with the enable
		apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_A002);
		tick(1'b1);
		cmp1(alarm_pulse, 1'b0);
		rdc(RTCAC_OFF_CTRL, 32'h0000_8001);
		apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_A001);
		rdc(RTCAC_OFF_CTRL, 32'h0000_8001);
		tick(1'b1);
		rdc(RTCAC_OFF_CTRL, 32'h0000_A000);
		tick(1'b1);
		rdc(RTCAC_OFF_CTRL, 32'h0000_0000);
		tick(1'b0);
		rdc(RTCAC_OFF_IRQ_STAT, 32'h0000_0003);
		cmp1(irq, 1'b0);
		apb(1'b1, RTCAC_OFF_IRQ_EN, 32'h0000_0001);
		#1;
		cmp1(irq, 1'b1);
		apb(1'b1, RTCAC_OFF_IRQ_CLR, 32'h0000_0001);
		#1;
		cmp1(irq, 1'b0);
		rdc(RTCAC_OFF_IRQ_STAT, 32'h0000_0002);
		apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_C000);
		tick(1'b1);
		rdc(RTCAC_OFF_CTRL, 32'h0000_E0FF);
		#1;
		cmp1(irq, 1'b1);
		// every interval code with all digits matching; reserved codes stay silent
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_8005 | (32'(c) << 8));
			tick(c < 10);
		end
		apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_8105);
		second_edge <= 1'b0;
		tick(1'b0);
		second_edge <= 1'b1;
		alarm_time.sec01 <= 4'h1;
		apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_8205);
		tick(1'b0);
		apb(1'b1, RTCAC_OFF_CTRL, 32'h0000_8105);
		tick(1'b1);
		alarm_time.sec01 <= 4'h0;
		do_reset();
		rdc(RTCAC_OFF_CTRL, 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
